/* File: hw/flow_pkg.sv */
// Shared constants for the flow sensor test-mode and pulse output logic
package flow_pkg;
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int CYC_PER_MS = SYS_CLK_HZ / 1000;

   // Power-up window after which a grounded verification input selects test mode
   localparam int ENTRY_TIME_MS = 1000;
   localparam int ENTRY_CYCLES = ENTRY_TIME_MS * CYC_PER_MS;

   // Verification input must be stable this long before an edge is accepted
   localparam int DEBOUNCE_TIME_MS = 2;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * CYC_PER_MS;

   // Normal-mode measuring interval; test mode runs TEST_SPEEDUP times faster
   localparam int MEAS_TIME_MS = 1000;
   localparam int MEAS_CYCLES = MEAS_TIME_MS * CYC_PER_MS;
   localparam int TEST_SPEEDUP = 4;

   // Pulse budget is computed once per second
   localparam int PULSE_SEC_MS = 1000;
   localparam int PULSE_SEC_CYCLES = PULSE_SEC_MS * CYC_PER_MS;

   // Pulse shape: high time, low time inside a burst, pause between bursts
   localparam int PULSE_HIGH_MS = 2;
   localparam int PULSE_HIGH_CYCLES = PULSE_HIGH_MS * CYC_PER_MS;
   localparam int PULSE_LOW_MS = 2;
   localparam int PULSE_LOW_CYCLES = PULSE_LOW_MS * CYC_PER_MS;
   localparam int BURST_GAP_MS = 30;
   localparam int BURST_GAP_CYCLES = BURST_GAP_MS * CYC_PER_MS;
   localparam int BURST_LEN = 8;

   // Saturation: at most this many pulses per second
   localparam int MAX_PULSE_HZ = 125;
   localparam int PULSE_CNT_W = 8;

   // Interval volume is fixed point in pulse units with this many fraction bits
   localparam int FRAC_BITS = 8;
   localparam int VOL_W = 16;
   localparam int ACC_W = 32;
   localparam int CUTOFF_DEFAULT = 4;

   // Reset values
   localparam logic VERIFY_IDLE_LEVEL = 1'b1;
endpackage

/* File: hw/pulse_if.sv */
// Carrier between the controller and the pulse burst generator
`timescale 1ns/1ns
interface pulse_if #(
   parameter int CNT_W = 8
);
   logic load;
   logic [CNT_W-1:0] count;
   logic abort;
   logic busy;
   logic pulse;

   modport ctrl (output load, output count, output abort, input busy, input pulse);
   modport gen (input load, input count, input abort, output busy, output pulse);
endinterface

/* File: hw/pulse_burst_gen.sv */
// Emits a loaded number of output pulses in bursts
`timescale 1ns/1ns
module pulse_burst_gen #(
   parameter int HIGH_CYCLES = flow_pkg::PULSE_HIGH_CYCLES,
   parameter int LOW_CYCLES = flow_pkg::PULSE_LOW_CYCLES,
   parameter int GAP_CYCLES = flow_pkg::BURST_GAP_CYCLES,
   parameter int BURST_LEN = flow_pkg::BURST_LEN,
   parameter int CNT_W = flow_pkg::PULSE_CNT_W
) (
   input wire logic clk,
   input wire logic arst_n,
   pulse_if.gen pif
);
   typedef enum {G_IDLE, G_HIGH, G_LOW, G_GAP} gen_state_e;

   gen_state_e state_r, state_nxt;
   logic [31:0] timer_r, timer_nxt;
   logic [CNT_W-1:0] rem_r, rem_nxt;
   logic [7:0] burst_r, burst_nxt;
   logic pulse_r, pulse_nxt;

   if (HIGH_CYCLES < 1 || LOW_CYCLES < 1 || GAP_CYCLES < 1 || BURST_LEN < 1 ||
       BURST_LEN > 255) begin : g_bad_param
      $error("pulse_burst_gen: unusable timing parameters");
   end

   always_comb begin
      state_nxt = state_r;
      timer_nxt = timer_r;
      rem_nxt = rem_r;
      burst_nxt = burst_r;
      pulse_nxt = pulse_r;
      if (timer_r != 32'h0) begin
         timer_nxt = timer_r - 32'h1;
      end
      case (state_r)
         G_HIGH: begin
            if (timer_r == 32'h0) begin
               pulse_nxt = 1'b0;
               rem_nxt = rem_r - 1'b1;
               if (rem_r == CNT_W'(1)) begin
                  state_nxt = G_IDLE;
                  burst_nxt = 8'h00;
               end else if (burst_r == 8'(BURST_LEN - 1)) begin
                  // Gap between bursts; the tail of the second is idle, so the
                  // pause after the last pulse depends on the pulse frequency
                  state_nxt = G_GAP;
                  burst_nxt = 8'h00;
                  timer_nxt = 32'(GAP_CYCLES - 1);
               end else begin
                  state_nxt = G_LOW;
                  burst_nxt = burst_r + 8'h01;
                  timer_nxt = 32'(LOW_CYCLES - 1);
               end
            end
         end
         G_LOW, G_GAP: begin
            if (timer_r == 32'h0) begin
               state_nxt = G_HIGH;
               pulse_nxt = 1'b1;
               timer_nxt = 32'(HIGH_CYCLES - 1);
            end
         end
         default: begin
            burst_nxt = 8'h00;
            pulse_nxt = 1'b0;
         end
      endcase
      // A new second's budget replaces what is left of the old one
      if (pif.load) begin
         rem_nxt = pif.count;
         if (state_r == G_IDLE && pif.count != '0) begin
            state_nxt = G_HIGH;
            pulse_nxt = 1'b1;
            burst_nxt = 8'h00;
            timer_nxt = 32'(HIGH_CYCLES - 1);
         end
      end
      if (pif.abort) begin
         state_nxt = G_IDLE;
         rem_nxt = '0;
         burst_nxt = 8'h00;
         pulse_nxt = 1'b0;
         timer_nxt = 32'h0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= G_IDLE;
         timer_r <= 32'h0;
         rem_r <= '0;
         burst_r <= 8'h00;
         pulse_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         timer_r <= timer_nxt;
         rem_r <= rem_nxt;
         burst_r <= burst_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   assign pif.pulse = pulse_r;
   assign pif.busy = (state_r != G_IDLE);
endmodule

/* File: hw/flow_test_ctrl.sv */
// Test mode, start/stop volume accumulation and pulse output control
`timescale 1ns/1ns
// Summary of operation
// - Test mode shortens every measuring interval to a quarter of normal.
// - About one second after power-up with input grounded, test mode starts.
// - Test mode ends only by power removal, i.e. by reset.
// - In test mode, grounding starts accumulation and releasing stops it.
// - Accumulated test volume stays available for serial readout.
// - Accumulator uses the same interval volumes as the pulse computation.
// - Interval volumes inside the test window are summed.
// - First and last interval volumes are weighted by their in-window fraction.
// - Pulse output stops as soon as the input is released at test end.
// - Pulses are managed per second, so pulse count may differ from volume.
// - Pause after the last pulse of a second follows pulse frequency; pulse width stays fixed.
// - Pulse count computed each second and emitted as bursts next second.
// - Pulses last two milliseconds; bursts separated by thirty milliseconds.
// - No pulses below cut-off or reverse flow; saturate at 125 per second.
module flow_test_ctrl #(
   parameter int ENTRY_CYCLES = flow_pkg::ENTRY_CYCLES,
   parameter int DEBOUNCE_CYCLES = flow_pkg::DEBOUNCE_CYCLES,
   parameter int MEAS_CYCLES = flow_pkg::MEAS_CYCLES,
   parameter int PULSE_SEC_CYCLES = flow_pkg::PULSE_SEC_CYCLES,
   parameter int PULSE_HIGH_CYCLES = flow_pkg::PULSE_HIGH_CYCLES,
   parameter int PULSE_LOW_CYCLES = flow_pkg::PULSE_LOW_CYCLES,
   parameter int BURST_GAP_CYCLES = flow_pkg::BURST_GAP_CYCLES,
   parameter int BURST_LEN = flow_pkg::BURST_LEN,
   parameter int MAX_PULSES = flow_pkg::MAX_PULSE_HZ,
   parameter int VOL_W = flow_pkg::VOL_W,
   parameter int ACC_W = flow_pkg::ACC_W,
   parameter int CUTOFF = flow_pkg::CUTOFF_DEFAULT
) (
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   input wire logic VERIFY_IN_N,
   input wire logic signed [VOL_W-1:0] FLOW_VOL,
   output logic MEAS_TICK,
   output logic TEST_MODE,
   output logic TEST_ACTIVE,
   output logic [ACC_W-1:0] TEST_VOL,
   output logic TEST_VOL_VALID,
   output logic PULSE_OUT
);
   localparam int CNT_W = flow_pkg::PULSE_CNT_W;
   localparam int TEST_CYCLES = MEAS_CYCLES / flow_pkg::TEST_SPEEDUP;
   localparam int PROD_W = VOL_W + 32;

   typedef enum {M_POWERUP, M_NORMAL, M_TEST_RELEASE, M_TEST_IDLE, M_TEST_RUN} mode_e;

   if (MEAS_CYCLES % flow_pkg::TEST_SPEEDUP != 0 || TEST_CYCLES < 2 ||
       ENTRY_CYCLES < 1 || DEBOUNCE_CYCLES < 1 || PULSE_SEC_CYCLES < 1 ||
       MAX_PULSES < 1 || MAX_PULSES > 255 || VOL_W < 2 ||
       ACC_W < VOL_W) begin : g_bad_param
      $error("flow_test_ctrl: unusable parameters");
   end

   // Scale an interval volume by elapsed/period for the current cadence
   function automatic logic [ACC_W-1:0] scale_vol(input logic [VOL_W-1:0] v,
                                                  input logic [31:0] t,
                                                  input logic fast);
      logic [PROD_W-1:0] prod;
      prod = PROD_W'(v) * PROD_W'(t);
      if (fast) begin
         scale_vol = ACC_W'(prod / PROD_W'(TEST_CYCLES));
      end else begin
         scale_vol = ACC_W'(prod / PROD_W'(MEAS_CYCLES));
      end
   endfunction

   // Input synchroniser and debounce
   logic sync1_r, sync1_nxt;
   logic sync2_r, sync2_nxt;
   logic stable_r, stable_nxt;
   logic [31:0] deb_cnt_r, deb_cnt_nxt;
   logic fall_r, fall_nxt;
   logic rise_r, rise_nxt;

   always_comb begin
      sync1_nxt = VERIFY_IN_N;
      sync2_nxt = sync1_r;
      stable_nxt = stable_r;
      deb_cnt_nxt = 32'h0;
      fall_nxt = 1'b0;
      rise_nxt = 1'b0;
      if (sync2_r != stable_r) begin
         deb_cnt_nxt = deb_cnt_r + 32'h1;
         if (deb_cnt_r == 32'(DEBOUNCE_CYCLES - 1)) begin
            stable_nxt = sync2_r;
            deb_cnt_nxt = 32'h0;
            fall_nxt = ~sync2_r;
            rise_nxt = sync2_r;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync1_r <= flow_pkg::VERIFY_IDLE_LEVEL;
         sync2_r <= flow_pkg::VERIFY_IDLE_LEVEL;
         stable_r <= flow_pkg::VERIFY_IDLE_LEVEL;
         deb_cnt_r <= 32'h0;
         fall_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         stable_r <= stable_nxt;
         deb_cnt_r <= deb_cnt_nxt;
         fall_r <= fall_nxt;
         rise_r <= rise_nxt;
      end
   end

   // Mode control; reset stands for power-up, so nothing else leaves test mode
   mode_e mode_r, mode_nxt;
   logic [31:0] entry_cnt_r, entry_cnt_nxt;
   logic test_mode_r, test_mode_nxt;
   logic test_run_r, test_run_nxt;
   logic start_ev, stop_ev;

   always_comb begin
      mode_nxt = mode_r;
      entry_cnt_nxt = entry_cnt_r;
      start_ev = 1'b0;
      stop_ev = 1'b0;
      case (mode_r)
         M_POWERUP: begin
            entry_cnt_nxt = entry_cnt_r + 32'h1;
            if (entry_cnt_r == 32'(ENTRY_CYCLES - 1)) begin
               // Grounded at the end of the window selects test mode
               if (!stable_r) begin
                  mode_nxt = M_TEST_RELEASE;
               end else begin
                  mode_nxt = M_NORMAL;
               end
            end
         end
         M_NORMAL: begin
            mode_nxt = M_NORMAL;
         end
         M_TEST_RELEASE: begin
            // The entry grounding must be released before it can start a test
            if (stable_r) begin
               mode_nxt = M_TEST_IDLE;
            end
         end
         M_TEST_IDLE: begin
            if (fall_r) begin
               mode_nxt = M_TEST_RUN;
               start_ev = 1'b1;
            end
         end
         M_TEST_RUN: begin
            if (rise_r) begin
               mode_nxt = M_TEST_IDLE;
               stop_ev = 1'b1;
            end
         end
         default: begin
            mode_nxt = M_POWERUP;
         end
      endcase
      test_mode_nxt = (mode_nxt == M_TEST_RELEASE) || (mode_nxt == M_TEST_IDLE) ||
                      (mode_nxt == M_TEST_RUN);
      test_run_nxt = (mode_nxt == M_TEST_RUN);
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode_r <= M_POWERUP;
         entry_cnt_r <= 32'h0;
         test_mode_r <= 1'b0;
         test_run_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         entry_cnt_r <= entry_cnt_nxt;
         test_mode_r <= test_mode_nxt;
         test_run_r <= test_run_nxt;
      end
   end

   // Measuring cadence
   logic [31:0] phase_r, phase_nxt;
   logic meas_tick_r, meas_tick_nxt;
   logic [31:0] period;
   logic tick;
   logic [VOL_W-1:0] vol_now;

   always_comb begin
      period = test_mode_r ? 32'(TEST_CYCLES) : 32'(MEAS_CYCLES);
      tick = (phase_r == period - 32'h1);
      phase_nxt = tick ? 32'h0 : phase_r + 32'h1;
      // Restart the interval grid when the cadence changes
      if (test_mode_r != test_mode_nxt) begin
         phase_nxt = 32'h0;
      end
      meas_tick_nxt = tick;
      // Reverse flow and flow below cut-off count as nothing
      if (FLOW_VOL[VOL_W-1] || FLOW_VOL < VOL_W'(CUTOFF)) begin
         vol_now = '0;
      end else begin
         vol_now = FLOW_VOL;
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         phase_r <= 32'h0;
         meas_tick_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         meas_tick_r <= meas_tick_nxt;
      end
   end

   // Test volume accumulation with start and stop correction
   logic [ACC_W-1:0] acc_r, acc_nxt;
   logic acc_valid_r, acc_valid_nxt;
   logic first_pend_r, first_pend_nxt;
   logic [31:0] start_counted_time_r, start_counted_time_nxt;
   logic [31:0] start_excess_time_r, start_excess_time_nxt;
   logic [VOL_W-1:0] last_vol_r, last_vol_nxt;
   logic [31:0] stop_counted_time;

   always_comb begin
      acc_nxt = acc_r;
      acc_valid_nxt = acc_valid_r;
      first_pend_nxt = first_pend_r;
      start_counted_time_nxt = start_counted_time_r;
      start_excess_time_nxt = start_excess_time_r;
      last_vol_nxt = tick ? vol_now : last_vol_r;
      stop_counted_time = first_pend_r ? phase_r - start_excess_time_r : phase_r;
      if (start_ev) begin
         acc_nxt = '0;
         acc_valid_nxt = 1'b0;
         first_pend_nxt = 1'b1;
         start_excess_time_nxt = phase_r;
         start_counted_time_nxt = period - phase_r;
         if (tick) begin
            // Start on the closing cycle of an interval: that cycle is folded into the next one
            start_excess_time_nxt = 32'hFFFF_FFFF;
            start_counted_time_nxt = period + 32'h1;
         end
      end else if (stop_ev) begin
         // Part of the running interval that lies before the stop
         acc_nxt = acc_r + scale_vol(last_vol_r, stop_counted_time, test_mode_r);
         acc_valid_nxt = 1'b1;
         first_pend_nxt = 1'b0;
      end else if (test_run_r && tick) begin
         if (first_pend_r) begin
            acc_nxt = acc_r + scale_vol(vol_now, start_counted_time_r, test_mode_r);
         end else begin
            acc_nxt = acc_r + ACC_W'(vol_now);
         end
         first_pend_nxt = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         acc_r <= '0;
         acc_valid_r <= 1'b0;
         first_pend_r <= 1'b0;
         start_counted_time_r <= 32'h0;
         start_excess_time_r <= 32'h0;
         last_vol_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         acc_valid_r <= acc_valid_nxt;
         first_pend_r <= first_pend_nxt;
         start_counted_time_r <= start_counted_time_nxt;
         start_excess_time_r <= start_excess_time_nxt;
         last_vol_r <= last_vol_nxt;
      end
   end

   // Per-second pulse budget; below saturation the fraction of a pulse carries into the next second
   logic [31:0] sec_cnt_r, sec_cnt_nxt;
   logic [ACC_W-1:0] sec_acc_r, sec_acc_nxt;
   logic [flow_pkg::FRAC_BITS-1:0] residue_r, residue_nxt;
   logic load_r, load_nxt;
   logic [CNT_W-1:0] count_r, count_nxt;
   logic abort_r, abort_nxt;
   logic [ACC_W-1:0] sec_total;
   logic [ACC_W-1:0] whole;

   always_comb begin
      sec_cnt_nxt = sec_cnt_r + 32'h1;
      sec_acc_nxt = sec_acc_r;
      residue_nxt = residue_r;
      load_nxt = 1'b0;
      count_nxt = count_r;
      abort_nxt = stop_ev;
      if (tick) begin
         sec_acc_nxt = sec_acc_r + ACC_W'(vol_now);
      end
      sec_total = sec_acc_nxt + ACC_W'(residue_r);
      whole = sec_total >> flow_pkg::FRAC_BITS;
      if (sec_cnt_r == 32'(PULSE_SEC_CYCLES - 1)) begin
         sec_cnt_nxt = 32'h0;
         sec_acc_nxt = '0;
         load_nxt = 1'b1;
         if (whole >= ACC_W'(MAX_PULSES)) begin
            // Saturated flow drops its remainder rather than banking it
            count_nxt = CNT_W'(MAX_PULSES);
            residue_nxt = '0;
         end else begin
            count_nxt = CNT_W'(whole);
            residue_nxt = sec_total[flow_pkg::FRAC_BITS-1:0];
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sec_cnt_r <= 32'h0;
         sec_acc_r <= '0;
         residue_r <= '0;
         load_r <= 1'b0;
         count_r <= '0;
         abort_r <= 1'b0;
      end else begin
         sec_cnt_r <= sec_cnt_nxt;
         sec_acc_r <= sec_acc_nxt;
         residue_r <= residue_nxt;
         load_r <= load_nxt;
         count_r <= count_nxt;
         abort_r <= abort_nxt;
      end
   end

   pulse_if #(.CNT_W(CNT_W)) pif ();

   assign pif.load = load_r;
   assign pif.count = count_r;
   assign pif.abort = abort_r;

   pulse_burst_gen #(
      .HIGH_CYCLES(PULSE_HIGH_CYCLES),
      .LOW_CYCLES(PULSE_LOW_CYCLES),
      .GAP_CYCLES(BURST_GAP_CYCLES),
      .BURST_LEN(BURST_LEN),
      .CNT_W(CNT_W)
   ) u_burst (
      .clk(SYS_CLK),
      .arst_n(ARST_N),
      .pif(pif)
   );

   assign MEAS_TICK = meas_tick_r;
   assign TEST_MODE = test_mode_r;
   assign TEST_ACTIVE = test_run_r;
   assign TEST_VOL = acc_r;
   assign TEST_VOL_VALID = acc_valid_r;
   assign PULSE_OUT = pif.pulse;
endmodule

/* File: bench/flow_bench_model.sv */
// Flow bench and test controller model: drives the verification pin and counts pulses
`timescale 1ns/1ns
module flow_bench_model (
   input wire logic clk,
   input wire logic pulse_in,
   output logic verify_n
);
   int count;
   logic pulse_q;

   initial begin
      verify_n = 1'b1;
      count = 0;
      pulse_q = 1'b0;
   end

   // Contact changes right after an edge; open contact reads high through the pull-up
   task automatic set_pin(input logic level);
      @(posedge clk);
      verify_n <= level;
   endtask

   // Counter input of the calculator: one count per rising edge
   always @(posedge clk) begin
      pulse_q <= pulse_in;
      if (pulse_in && !pulse_q) begin
         count <= count + 1;
      end
   end
endmodule

/* File: bench/flow_test_ctrl_chk.sv */
// Concurrent checks on the ports of the flow test controller
`timescale 1ns/1ns
module flow_test_ctrl_chk #(
   parameter int ENTRY_CYCLES = flow_pkg::ENTRY_CYCLES,
   parameter int MEAS_CYCLES = flow_pkg::MEAS_CYCLES,
   parameter int PULSE_HIGH_CYCLES = flow_pkg::PULSE_HIGH_CYCLES,
   parameter int VOL_W = flow_pkg::VOL_W,
   parameter int ACC_W = flow_pkg::ACC_W
) (
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   input wire logic VERIFY_IN_N,
   input wire logic signed [VOL_W-1:0] FLOW_VOL,
   input wire logic MEAS_TICK,
   input wire logic TEST_MODE,
   input wire logic TEST_ACTIVE,
   input wire logic [ACC_W-1:0] TEST_VOL,
   input wire logic TEST_VOL_VALID,
   input wire logic PULSE_OUT
);
   localparam int NORM_GAP = MEAS_CYCLES - 1;
   localparam int TEST_GAP = MEAS_CYCLES / 4 - 1;
   int up_r, up_nxt, hi_r, hi_nxt, gap_r, gap_nxt;
   logic seen_r, seen_nxt, tm_r, tm_nxt;

   always_comb begin
      up_nxt = (up_r < ENTRY_CYCLES + 8) ? up_r + 1 : up_r;
      hi_nxt = PULSE_OUT ? hi_r + 1 : 0;
      gap_nxt = MEAS_TICK ? 0 : gap_r + 1;
      seen_nxt = seen_r | MEAS_TICK;
      // Only a tick inside test mode starts a full fast interval
      tm_nxt = tm_r | (MEAS_TICK & TEST_MODE);
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         up_r <= 0;
         hi_r <= 0;
         gap_r <= 0;
         seen_r <= 1'b0;
         tm_r <= 1'b0;
      end else begin
         up_r <= up_nxt;
         hi_r <= hi_nxt;
         gap_r <= gap_nxt;
         seen_r <= seen_nxt;
         tm_r <= tm_nxt;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_start;
      $rose(TEST_ACTIVE);
   endsequence
   sequence s_quiet;
      ##[0:2] (!PULSE_OUT) [*4];
   endsequence

   a_mode_sticky: assert property (TEST_MODE |=> TEST_MODE)
      else $error("test mode left without power loss");
   a_entry_time: assert property ($rose(TEST_MODE) |->
      up_r >= ENTRY_CYCLES - 1 && up_r <= ENTRY_CYCLES + 3)
      else $error("test mode entered at wrong time");
   a_tick_fast: assert property (MEAS_TICK && TEST_MODE && tm_r |-> gap_r == TEST_GAP)
      else $error("test mode interval not a quarter");
   a_tick_normal: assert property (MEAS_TICK && !TEST_MODE && seen_r |-> gap_r == NORM_GAP)
      else $error("normal interval wrong");
   a_active_mode: assert property (TEST_ACTIVE |-> TEST_MODE)
      else $error("accumulation outside test mode");
   a_start_clear: assert property (s_start |-> TEST_VOL == '0 && !TEST_VOL_VALID)
      else $error("start did not clear volume");
   a_stop_valid: assert property ($fell(TEST_ACTIVE) |-> TEST_VOL_VALID)
      else $error("volume not valid after stop");
   a_vol_hold: assert property (TEST_VOL_VALID && $past(TEST_VOL_VALID) |-> $stable(TEST_VOL))
      else $error("volume changed while held");
   a_pulse_stop: assert property ($fell(TEST_ACTIVE) |-> s_quiet)
      else $error("pulses continue after stop");
   a_start_debounce: assert property (s_start |->
      !$past(VERIFY_IN_N, 4) && !$past(VERIFY_IN_N, 6))
      else $error("start taken from unsettled input");
   a_pulse_width: assert property ($fell(PULSE_OUT) && $past(TEST_ACTIVE, 4) == TEST_ACTIVE
      |-> hi_r == PULSE_HIGH_CYCLES)
      else $error("pulse width wrong");
endmodule

bind flow_test_ctrl flow_test_ctrl_chk #(.ENTRY_CYCLES(ENTRY_CYCLES), .MEAS_CYCLES(MEAS_CYCLES),
   .PULSE_HIGH_CYCLES(PULSE_HIGH_CYCLES)) chk (
   .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .VERIFY_IN_N(VERIFY_IN_N), .FLOW_VOL(FLOW_VOL),
   .MEAS_TICK(MEAS_TICK), .TEST_MODE(TEST_MODE), .TEST_ACTIVE(TEST_ACTIVE),
   .TEST_VOL(TEST_VOL), .TEST_VOL_VALID(TEST_VOL_VALID), .PULSE_OUT(PULSE_OUT));

/* File: bench/testbench.sv */
// Self-checking bench for the flow test controller
`timescale 1ns/1ns
module testbench;
   logic sys_clk;
   logic arst_n;
   logic signed [flow_pkg::VOL_W-1:0] flow_vol;
   logic verify_n, meas_tick, test_mode, test_active, test_vol_valid, pulse_out;
   logic [flow_pkg::ACC_W-1:0] test_vol;
   int miscompares = 0;
   int comparisons = 0;
   int base;

   // Shortened counts keep the run small; one second is 2000 cycles here
   flow_test_ctrl #(.ENTRY_CYCLES(200), .DEBOUNCE_CYCLES(4), .MEAS_CYCLES(400),
      .PULSE_SEC_CYCLES(2000), .PULSE_HIGH_CYCLES(5), .PULSE_LOW_CYCLES(5),
      .BURST_GAP_CYCLES(40)) uut (
      .SYS_CLK(sys_clk), .ARST_N(arst_n), .VERIFY_IN_N(verify_n), .FLOW_VOL(flow_vol),
      .MEAS_TICK(meas_tick), .TEST_MODE(test_mode), .TEST_ACTIVE(test_active),
      .TEST_VOL(test_vol), .TEST_VOL_VALID(test_vol_valid), .PULSE_OUT(pulse_out));
   flow_bench_model mdl (.clk(sys_clk), .pulse_in(pulse_out), .verify_n(verify_n));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic power_up(input logic pin);
      mdl.set_pin(pin);
      arst_n <= 1'b0;
      cyc(6);
      arst_n <= 1'b1;
   endtask

   task automatic test_done();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Interval volume is a multiple of the fast interval length, so the
   // corrected volume is exactly 10 units per cycle the pin was grounded
   task automatic t_test();
      int lens[2] = '{350, 60};
      power_up(1'b0);
      flow_vol <= 16'sd1000;
      cyc(230);
      check(test_mode, 1'b1);
      mdl.set_pin(1'b1);
      cyc(30);
      check(test_active, 1'b0);
      mdl.set_pin(1'b0);
      cyc(1);
      mdl.set_pin(1'b1);
      cyc(20);
      check(test_active, 1'b0);
      cyc(1640);
      foreach (lens[i]) begin
         mdl.set_pin(1'b0);
         cyc(lens[i] - 1);
         mdl.set_pin(1'b1);
         cyc(15);
         check(pulse_out, 1'b0);
         check(test_active, 1'b0);
         check(test_vol_valid, 1'b1);
         check(test_vol, 32'(lens[i] * 10));
         // Two seconds later the volume must still hold the same value for readout
         cyc(4000);
         check(test_vol, 32'(lens[i] * 10));
      end
      $display("test mode accumulation done");
   endtask

   task automatic t_normal();
      power_up(1'b1);
      cyc(230);
      check(test_mode, 1'b0);
      mdl.set_pin(1'b0);
      cyc(40);
      check(test_active, 1'b0);
      mdl.set_pin(1'b1);
      cyc(40);
      check(test_mode, 1'b0);
      $display("normal power-up done");
   endtask

   // Count windows start just before a second boundary, so each holds whole bursts;
   // 272 leaves a carried fraction of 224 that a leaky cut-off would push past a pulse
   task automatic t_pulses();
      logic signed [15:0] vals[3] = '{16'sd272, -16'sd1000, 16'sd3};
      int exps[3] = '{5, 0, 0};
      power_up(1'b1);
      flow_vol <= 16'sh7FFF;
      cyc(3989);
      base = mdl.count;
      cyc(6000);
      check(mdl.count - base, 375);
      foreach (vals[i]) begin
         flow_vol <= vals[i];
         cyc(4000);
         base = mdl.count;
         cyc(2000);
         check(mdl.count - base, exps[i]);
      end
      $display("pulse output done");
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial begin
      arst_n = 1'b0;
      flow_vol = '0;
      t_test();
      t_normal();
      t_pulses();
      test_done();
   end

   // Whole run needs about 38700 cycles
   initial begin
      cyc(45000);
      miscompares++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
